/* pwd_load_model.sv */
// external load model: integrates the time the pwm pin is high
`timescale 1ns/1ps
module pwd_load_model (
    input  wire logic        clk,
    input  wire logic        count_clr,
    input  wire logic        pwm_out,
    output      logic [15:0] high_count
);
    // a resistive load only integrates on-time; it never drives back
    always_ff @(posedge clk) begin
        if (count_clr) begin
            high_count <= 16'h0000;
        end else if (pwm_out) begin
            high_count <= high_count + 16'h0001;
        end
    end
endmodule

/* pwd_ontime.sv */
// on-time calculation: period times duty over full scale
`timescale 1ns/1ps
module pwd_ontime (
    input  wire logic [15:0] period,
    input  wire logic [15:0] duty,
    output      logic [15:0] on_time,
    output      logic        is_zero,
    output      logic        is_full
);
    // ------------------------------------------------------------
    // scaling
    // ------------------------------------------------------------
    wire logic [15:0] clamped;
    wire logic [31:0] product;
    assign clamped = (duty > pwd_pkg::DUTY_FULL) ? pwd_pkg::DUTY_FULL : duty;
    assign product = period * clamped;
    assign on_time = product[pwd_pkg::DUTY_SHIFT +: 16];
    assign is_zero = (clamped == pwd_pkg::DUTY_ZERO);
    assign is_full = (clamped == pwd_pkg::DUTY_FULL);
endmodule

/* pwd_pkg.sv */
// package: register map, field layout and constants of the duty scaler pwm
package pwd_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [4:0] OFF_CTRL    = 5'h00;
    localparam logic [4:0] OFF_PERIOD  = 5'h04;
    localparam logic [4:0] OFF_DUTY    = 5'h08;
    localparam logic [4:0] OFF_STATUS  = 5'h0c;
    localparam logic [4:0] OFF_IRQ_ST  = 5'h10;
    localparam logic [4:0] OFF_IRQ_MSK = 5'h14;
    localparam logic [4:0] OFF_ERR     = 5'h18;
    localparam logic [4:0] OFF_SHIFT   = 5'h1c;
    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_EN       = 0;
    localparam int CTRL_POL      = 1;
    localparam int CTRL_IDLE     = 2;
    localparam int CTRL_EDGE_LO  = 3;
    localparam int CTRL_CLASS_LO = 5;
    localparam int CTRL_NOTE     = 7;
    // irq status bits
    localparam int IRQ_EDGE = 0;
    localparam int IRQ_ERR  = 1;
    // ------------------------------------------------------------
    // widths, resets, codes
    // ------------------------------------------------------------
    localparam int DUTY_W   = 16;
    localparam int PERIOD_W = 16;
    localparam logic [15:0] DUTY_FULL      = 16'h8000;
    localparam logic [15:0] DUTY_ZERO      = 16'h0000;
    localparam int          DUTY_SHIFT     = 15;
    localparam logic [15:0] PERIOD_RST     = 16'h03e8;
    localparam logic [15:0] DUTY_RST       = 16'h4000;
    localparam logic [15:0] SHIFT_RST      = 16'h0000;
    localparam logic [7:0]  CTRL_RST       = 8'h01;
    localparam logic [7:0]  ERR_NONE       = 8'h00;
    localparam logic [7:0]  err_period_locked = 8'h13;

    typedef enum logic [1:0] {
        EDGE_RISING             = 2'b00,
        EDGE_FALLING            = 2'b01,
        event_on_any_transition = 2'b10
    } pwd_edge_type;

    typedef enum logic [1:0] {
        CLASS_VARIABLE      = 2'b00,
        CLASS_FIXED         = 2'b01,
        CLASS_FIXED_SHIFTED = 2'b10
    } pwd_class_type;
endpackage

/* pwd_top.sv */
// duty-scaled pwm channel with avalon-mm register slave
`timescale 1ns/1ps
module pwd_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output      logic [31:0] avs_readdata,
    output      logic        avs_waitrequest,
    output      logic        pwm_out,
    output      logic        irq
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  ctrl;
    logic [15:0] period;
    logic [15:0] duty;
    logic [15:0] shift;
    logic [15:0] cnt;
    logic [15:0] on_act;
    logic        zero_act;
    logic        full_act;
    logic        level;
    logic        level_d;
    logic [1:0]  irq_st;
    logic [1:0]  irq_msk;
    logic [7:0]  err_code;
    logic        ack;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire logic req      = (avs_read | avs_write) & ~ack;
    // a write lands on the edge that sees waitrequest low
    wire logic wr       = avs_write & ack;
    wire logic lo_en    = avs_byteenable[0];
    wire logic hi_en    = avs_byteenable[1];
    wire logic sel_ctrl = (avs_address == pwd_pkg::OFF_CTRL);
    wire logic sel_per  = (avs_address == pwd_pkg::OFF_PERIOD);
    wire logic sel_duty = (avs_address == pwd_pkg::OFF_DUTY);
    wire logic sel_ist  = (avs_address == pwd_pkg::OFF_IRQ_ST);
    wire logic sel_msk  = (avs_address == pwd_pkg::OFF_IRQ_MSK);
    wire logic sel_err  = (avs_address == pwd_pkg::OFF_ERR);
    wire logic sel_sh   = (avs_address == pwd_pkg::OFF_SHIFT);
    wire logic sel_st_rd = (avs_address == pwd_pkg::OFF_STATUS);
    wire logic [1:0] cls = ctrl[pwd_pkg::CTRL_CLASS_LO +: 2];
    wire logic [1:0] edg = ctrl[pwd_pkg::CTRL_EDGE_LO +: 2];
    wire logic enable  = ctrl[pwd_pkg::CTRL_EN];
    wire logic pol     = ctrl[pwd_pkg::CTRL_POL];
    wire logic idle_lv = ctrl[pwd_pkg::CTRL_IDLE];
    wire logic notify  = ctrl[pwd_pkg::CTRL_NOTE];
    wire logic per_wr  = wr & sel_per;
    // only variable class may retune period
    wire logic per_ok  = (cls == pwd_pkg::CLASS_VARIABLE);
    wire logic per_bad = per_wr & ~per_ok;
    // shift is locked outside of variable class too
    wire logic sh_ok   = wr & sel_sh & per_ok;
    wire logic sh_bad  = wr & sel_sh & ~per_ok;

    // ------------------------------------------------------------
    // duty scaling
    // ------------------------------------------------------------
    wire logic [15:0] on_new;
    wire logic        zero_new;
    wire logic        full_new;
    pwd_ontime u_ontime (
        .period  (period),
        .duty    (duty),
        .on_time (on_new),
        .is_zero (zero_new),
        .is_full (full_new)
    );

    // ------------------------------------------------------------
    // counter and level
    // ------------------------------------------------------------
    wire logic last     = (cnt >= period - 16'h0001) | (period == 16'h0000);
    wire logic [15:0] next_cnt = last ? 16'h0000 : cnt + 16'h0001;
    // phase shift moves the on window start
    wire logic [15:0] phase = cnt - shift;
    wire logic shifted  = (cls == pwd_pkg::CLASS_FIXED_SHIFTED);
    wire logic [15:0] pos = shifted ? phase : cnt;
    wire logic in_on    = (pos < on_act) & (pos < period);
    wire logic active   = full_act ? 1'b1 : (zero_act ? 1'b0 : in_on);
    wire logic next_level = enable ? (active ? pol : ~pol) : idle_lv;
    wire logic rise     = level & ~level_d;
    wire logic fall     = ~level & level_d;
    wire logic edge_hit =
        (edg == pwd_pkg::EDGE_RISING  && rise) ||
        (edg == pwd_pkg::EDGE_FALLING && fall) ||
        (edg == pwd_pkg::event_on_any_transition && (rise || fall));
    wire logic [1:0] events = {per_bad | sh_bad, edge_hit & notify};
    wire logic [1:0] clr    = (wr & sel_ist & lo_en) ?
                              avs_writedata[1:0] : 2'b00;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt      <= 16'h0000;
            on_act   <= 16'h0000;
            zero_act <= 1'b0;
            full_act <= 1'b0;
        end else begin
            cnt <= next_cnt;
            // new duty settings take effect at the period boundary; period, shift and ctrl act at once
            if (last) begin
                on_act   <= on_new;
                zero_act <= zero_new;
                full_act <= full_new;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            level   <= 1'b0;
            level_d <= 1'b0;
        end else begin
            level   <= next_level;
            level_d <= level;
        end
    end
    assign pwm_out = level;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl   <= pwd_pkg::CTRL_RST;
            period <= pwd_pkg::PERIOD_RST;
            duty   <= pwd_pkg::DUTY_RST;
            shift  <= pwd_pkg::SHIFT_RST;
        end else begin
            if (wr && sel_ctrl && lo_en)
                ctrl <= avs_writedata[7:0];
            if (per_wr && per_ok) begin
                if (lo_en) period[7:0]  <= avs_writedata[7:0];
                if (hi_en) period[15:8] <= avs_writedata[15:8];
            end
            if (wr && sel_duty) begin
                if (lo_en) duty[7:0]  <= avs_writedata[7:0];
                if (hi_en) duty[15:8] <= avs_writedata[15:8];
            end
            if (sh_ok) begin
                if (lo_en) shift[7:0]  <= avs_writedata[7:0];
                if (hi_en) shift[15:8] <= avs_writedata[15:8];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_st   <= 2'b00;
            irq_msk  <= 2'b00;
            err_code <= pwd_pkg::ERR_NONE;
            irq      <= 1'b0;
        end else begin
            irq_st <= (irq_st & ~clr) | events;
            if (wr && sel_msk && lo_en)
                irq_msk <= avs_writedata[1:0];
            if (per_bad || sh_bad)
                err_code <= pwd_pkg::err_period_locked;
            else if (wr && sel_err && lo_en)
                err_code <= pwd_pkg::ERR_NONE;
            irq <= |(((irq_st & ~clr) | events) & irq_msk);
        end
    end

    // ------------------------------------------------------------
    // read path: one wait cycle then ack
    // ------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            pwd_pkg::OFF_CTRL:    rd_mux = {24'h00_0000, ctrl};
            pwd_pkg::OFF_PERIOD:  rd_mux = {16'h0000, period};
            pwd_pkg::OFF_DUTY:    rd_mux = {16'h0000, duty};
            pwd_pkg::OFF_STATUS:  rd_mux = {31'h0000_0000, level};
            pwd_pkg::OFF_IRQ_ST:  rd_mux = {30'h0000_0000, irq_st};
            pwd_pkg::OFF_IRQ_MSK: rd_mux = {30'h0000_0000, irq_msk};
            pwd_pkg::OFF_ERR:     rd_mux = {24'h00_0000, err_code};
            pwd_pkg::OFF_SHIFT:   rd_mux = {16'h0000, shift};
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            // one wait state: the answer lands the cycle after the take
            avs_waitrequest <= ~req;
            if (avs_read && !ack)
                avs_readdata <= rd_mux;
        end
    end
    assign ack = ~avs_waitrequest;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // bus checks
    // ------------------------------------------------------------
    chk_bus_answer: assert property (
        req |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");

    chk_idle_wait: assert property (
        !$past(req) |-> avs_waitrequest)
        else $error("waitrequest low without a request");

    chk_status_lvl: assert property (
        avs_read && !ack && sel_st_rd |=> avs_readdata[0] == $past(level))
        else $error("status level wrong");

    // ------------------------------------------------------------
    // register checks
    // ------------------------------------------------------------
    chk_locked_period: assert property (
        per_bad |=> $stable(period) &&
        err_code == pwd_pkg::err_period_locked && irq_st[1])
        else $error("locked period changed or no error");

    chk_shift_locked: assert property (
        sh_bad |=> $stable(shift) &&
        err_code == pwd_pkg::err_period_locked && irq_st[1])
        else $error("locked shift changed or no error");

    chk_fixed_const: assert property (
        cls != pwd_pkg::CLASS_VARIABLE |=> $stable(period))
        else $error("period moved outside variable class");

    chk_var_period: assert property (
        per_wr && per_ok && avs_byteenable[1:0] == 2'b11
        |=> period == $past(avs_writedata[15:0]))
        else $error("variable period not updated");

    chk_duty_write: assert property (
        wr && sel_duty && avs_byteenable[1:0] == 2'b11
        |=> duty == $past(avs_writedata[15:0]))
        else $error("duty not stored");

    chk_err_clear: assert property (
        wr && sel_err && lo_en |=> err_code == pwd_pkg::ERR_NONE)
        else $error("error code not cleared");

    // ------------------------------------------------------------
    // scaling and output checks
    // ------------------------------------------------------------
    chk_clamp: assert property (
        duty > 16'h8000 |-> full_new)
        else $error("duty above full not clamped");

    chk_ontime_max: assert property (
        on_new <= period)
        else $error("on time longer than period");

    chk_full_scale: assert property (
        full_new |-> on_new == period)
        else $error("full scale on time wrong");

    chk_zero_scale: assert property (
        duty == pwd_pkg::DUTY_ZERO |-> zero_new && on_new == 16'h0000)
        else $error("zero scale on time wrong");

    chk_cnt_wrap: assert property (
        last |=> cnt == 16'h0000)
        else $error("counter did not wrap");

    chk_on_load: assert property (
        last |=> on_act == $past(on_new))
        else $error("on time not loaded at boundary");

    chk_zero_static: assert property (
        enable && zero_act && $past(enable) |=> pwm_out == ~$past(pol))
        else $error("zero duty not static");

    chk_full_static: assert property (
        enable && full_act && $past(enable) |=> pwm_out == $past(pol))
        else $error("full duty not static");

    // the first tick after release still sees the reset level
    chk_modulate: assert property (
        enable && !zero_act && !full_act && !$past(rst)
        |=> pwm_out == ($past(in_on) ~^ $past(pol)))
        else $error("modulated level wrong");

    // ------------------------------------------------------------
    // event checks
    // ------------------------------------------------------------
    chk_edge_event: assert property (
        edge_hit && notify |=> irq_st[0])
        else $error("edge event lost");

    chk_w1c_clear: assert property (
        clr[0] && !events[0] |=> !irq_st[0])
        else $error("edge status not cleared");

    chk_notify_gate: assert property (
        !notify |-> !events[0])
        else $error("edge event raised while notification off");

    chk_notify_off: assert property (
        !notify && !clr[0] && !irq_st[0] |=> !irq_st[0])
        else $error("event without notification");

    chk_irq_level: assert property (
        irq == |(irq_st & $past(irq_msk)))
        else $error("interrupt level wrong");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    cov_rise: cover property (rise);
    cov_fall: cover property (fall);
    cov_locked: cover property (per_bad);
    cov_irq: cover property (irq);
    cov_shifted: cover property (shifted && in_on);
endmodule

/* pwm_channel_duty_scaler_tb_top.sv */
// self-checking bench for the duty scaled pwm channel
`timescale 1ns/1ps
module pwm_channel_duty_scaler_tb_top;
    logic        clk;
    logic        rst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        pwm_out;
    logic        irq;
    logic        count_clr;
    logic [15:0] high_count;
    logic [31:0] rd;
    int          fail_count;
    int          num_checks;

    pwd_top u_dut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pwm_out(pwm_out), .irq(irq));
    pwd_load_model u_load (.clk(clk), .count_clr(count_clr),
        .pwm_out(pwm_out), .high_count(high_count));

    // ------------------------------------------------------------
    // report and compare
    // ------------------------------------------------------------
    task automatic final_report();
        if (fail_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check_word(input string nm, input logic [31:0] e,
                              input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask

    task automatic check_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
            fail_count++;
        end
    endtask

    // ------------------------------------------------------------
    // avalon-mm master: hold until waitrequest sampled low
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            fail_count++;
            final_report();
        end else begin
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read  <= 1'b0;
        end
    endtask

    task automatic wreg(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [4:0] a,
                        input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        check_word(nm, e, rd);
    endtask

    // high cycles over four whole periods, phase independent
    task automatic measure(input int per, input logic [15:0] e);
        @(posedge clk);
        count_clr <= 1'b1;
        @(posedge clk);
        count_clr <= 1'b0;
        repeat (4 * per) @(posedge clk);
        #1;
        check_word("high_count", {16'h0000, e}, {16'h0000, high_count});
    endtask

    // static level reads back as is; a modulated one must show both
    task automatic status_chk(input logic [15:0] e);
        logic seen_hi;
        logic seen_lo;
        seen_hi = 1'b0;
        seen_lo = 1'b0;
        if (e == 16'd0 || e == 16'd80) begin
            rchk("status", pwd_pkg::OFF_STATUS,
                 {31'h0, e == 16'd80});
        end else begin
            // reads every 3 cycles walk all phases of a 20 cycle period
            for (int k = 0; k < 20; k++) begin
                bus(1'b0, pwd_pkg::OFF_STATUS, 32'h0000_0000);
                if (rd[0] === 1'b1) seen_hi = 1'b1;
                if (rd[0] === 1'b0) seen_lo = 1'b1;
            end
            check_bit("status_high", 1'b1, seen_hi);
            check_bit("status_low", 1'b1, seen_lo);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rchk("ctrl", pwd_pkg::OFF_CTRL, 32'h0000_0001);
        rchk("period", pwd_pkg::OFF_PERIOD, 32'h0000_03e8);
        rchk("duty", pwd_pkg::OFF_DUTY, 32'h0000_4000);
        rchk("mask", pwd_pkg::OFF_IRQ_MSK, 32'h0000_0000);
        rchk("err", pwd_pkg::OFF_ERR, 32'h0000_0000);
        check_bit("irq", 1'b0, irq);
    endtask

    // period 20: on = 20 * min(duty, 0x8000) / 32768, four periods
    task automatic t_duty();
        logic [15:0] dt [7] = '{16'h4000, 16'h2000, 16'h6000, 16'h0001,
                                16'h8000, 16'hffff, 16'h0000};
        logic [15:0] ex [7] = '{16'd40, 16'd20, 16'd60, 16'd0,
                                16'd80, 16'd80, 16'd0};
        wreg(pwd_pkg::OFF_CTRL, 32'h0000_0003);
        wreg(pwd_pkg::OFF_PERIOD, 32'h0000_0014);
        repeat (1100) @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            wreg(pwd_pkg::OFF_DUTY, {16'h0000, dt[i]});
            repeat (50) @(posedge clk);
            measure(20, ex[i]);
            status_chk(ex[i]);
        end
        wreg(pwd_pkg::OFF_CTRL, 32'h0000_0001);
        repeat (50) @(posedge clk);
        measure(20, 16'd80);
        wreg(pwd_pkg::OFF_CTRL, 32'h0000_0003);
        wreg(pwd_pkg::OFF_PERIOD, 32'h0000_0028);
        wreg(pwd_pkg::OFF_DUTY, 32'h0000_4000);
        repeat (100) @(posedge clk);
        measure(40, 16'd80);
        wreg(pwd_pkg::OFF_PERIOD, 32'h0000_0014);
        repeat (100) @(posedge clk);
    endtask

    // static high to low gives one falling edge, back gives one rising
    task automatic t_edges();
        logic [1:0] m;
        wreg(pwd_pkg::OFF_IRQ_MSK, 32'h0000_0003);
        for (int i = 0; i < 3; i++) begin
            m = i[1:0];
            wreg(pwd_pkg::OFF_DUTY, 32'h0000_8000);
            repeat (50) @(posedge clk);
            wreg(pwd_pkg::OFF_CTRL, {24'h0, 3'b100, m, 3'b011});
            wreg(pwd_pkg::OFF_IRQ_ST, 32'h0000_0003);
            wreg(pwd_pkg::OFF_DUTY, 32'h0000_0000);
            repeat (50) @(posedge clk);
            rchk("fall_event", pwd_pkg::OFF_IRQ_ST, {31'h0, m != 0});
            check_bit("irq_fall", m != 0, irq);
            wreg(pwd_pkg::OFF_IRQ_ST, 32'h0000_0003);
            wreg(pwd_pkg::OFF_DUTY, 32'h0000_8000);
            repeat (50) @(posedge clk);
            rchk("rise_event", pwd_pkg::OFF_IRQ_ST, {31'h0, m != 1});
            wreg(pwd_pkg::OFF_IRQ_ST, 32'h0000_0003);
        end
    endtask

    // locked period and shift writes, masked then unmasked error irq
    task automatic t_refuse();
        wreg(pwd_pkg::OFF_IRQ_MSK, 32'h0000_0000);
        wreg(pwd_pkg::OFF_CTRL, 32'h0000_0023);
        wreg(pwd_pkg::OFF_IRQ_ST, 32'h0000_0003);
        wreg(pwd_pkg::OFF_PERIOD, 32'h0000_0030);
        rchk("period_kept", pwd_pkg::OFF_PERIOD, 32'h0000_0014);
        rchk("err_code", pwd_pkg::OFF_ERR, 32'h0000_0013);
        rchk("err_flag", pwd_pkg::OFF_IRQ_ST, 32'h0000_0002);
        check_bit("irq_masked", 1'b0, irq);
        wreg(pwd_pkg::OFF_IRQ_MSK, 32'h0000_0002);
        repeat (2) @(posedge clk);
        check_bit("irq_unmasked", 1'b1, irq);
        wreg(pwd_pkg::OFF_IRQ_ST, 32'h0000_0002);
        repeat (2) @(posedge clk);
        check_bit("irq_cleared", 1'b0, irq);
        wreg(pwd_pkg::OFF_DUTY, 32'h0000_1234);
        rchk("duty_fixed", pwd_pkg::OFF_DUTY, 32'h0000_1234);
        wreg(pwd_pkg::OFF_ERR, 32'h0000_0000);
        wreg(pwd_pkg::OFF_CTRL, 32'h0000_0043);
        wreg(pwd_pkg::OFF_SHIFT, 32'h0000_0005);
        rchk("shift_kept", pwd_pkg::OFF_SHIFT, 32'h0000_0000);
        rchk("err_shift", pwd_pkg::OFF_ERR, 32'h0000_0013);
        wreg(pwd_pkg::OFF_CTRL, 32'h0000_0003);
        wreg(pwd_pkg::OFF_PERIOD, 32'h0000_0030);
        rchk("period_var", pwd_pkg::OFF_PERIOD, 32'h0000_0030);
    endtask

    // ------------------------------------------------------------
    // clock, reset, sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        rst            = 1'b1;
        avs_address    = 5'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hf;
        count_clr      = 1'b0;
        fail_count     = 0;
        num_checks     = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_duty();
        t_edges();
        t_refuse();
        final_report();
    end
endmodule
